// *** src/port_cfg_pkg.sv ***
// Constants for the port pin configuration block: register map, reset values, pin layout.
// Assumes a 32-bit APB bus and four 8-pin ports flattened to one 32-bit pin vector.
package port_cfg_pkg;
   localparam int NPIN  = 32;
   localparam int NFUNC = 3;
   localparam int PIN_IDX_W = 5;

   // Register byte offsets
   localparam logic [7:0] OFS_CTRL         = 8'h00;
   localparam logic [7:0] OFS_ANALOG_DIG   = 8'h04;
   localparam logic [7:0] OFS_DRIVE_SEL    = 8'h08;
   localparam logic [7:0] OFS_BYPASS       = 8'h0c;
   localparam logic [7:0] OFS_OUT_LATCH    = 8'h10;
   localparam logic [7:0] OFS_PIN_READ     = 8'h14;
   localparam logic [7:0] OFS_MATCH_MASK   = 8'h18;
   localparam logic [7:0] OFS_MATCH_VALUE  = 8'h1c;
   localparam logic [7:0] OFS_MATRIX_SEL   = 8'h20;
   localparam logic [7:0] OFS_EXT_IRQ_CFG  = 8'h24;

   // Field positions
   localparam int CTRL_MATRIX_EN_BIT   = 0;
   localparam int CTRL_PULLUP_DIS_BIT  = 1;
   localparam int MSEL_SERIAL_BIT      = 0;
   localparam int MSEL_FUNC_LSB        = 1;
   localparam int IRQ0_SEL_LSB         = 0;
   localparam int IRQ0_POL_BIT         = 3;
   localparam int IRQ1_SEL_LSB         = 4;
   localparam int IRQ1_POL_BIT         = 7;
   localparam int IRQ_SEL_W            = 3;
   localparam logic [4:0] IRQ_PORT_BASE = 5'h08;

   // Fixed serial pins, port 0 pins 4 and 5
   localparam int SERIAL_TX_PIN = 4;
   localparam int SERIAL_RX_PIN = 5;
   localparam logic [31:0] SERIAL_PIN_MASK = 32'h0000_0030;

   // Reset values
   localparam logic [31:0] RST_ANALOG_DIG  = 32'hffff_ffff;
   localparam logic [31:0] RST_DRIVE_SEL   = 32'h0000_0000;
   localparam logic [31:0] RST_BYPASS      = 32'h0000_0000;
   localparam logic [31:0] RST_OUT_LATCH   = 32'hffff_ffff;
   localparam logic [31:0] RST_MATCH_MASK  = 32'h0000_0000;
   localparam logic [31:0] RST_MATCH_VALUE = 32'h0000_0000;
   localparam logic [1:0]  RST_CTRL        = 2'h0;
   localparam logic [3:0]  RST_MATRIX_SEL  = 4'h0;
   localparam logic [7:0]  RST_EXT_IRQ_CFG = 8'h00;
endpackage

// *** src/pin_matrix_assign.sv ***
// Pin assignment matrix: gives each enabled function the lowest free pin.
// Assumes the caller registers the results before they reach pads.
`timescale 1ns/10ps
`default_nettype none
module pin_matrix_assign (
   input  wire logic                        i_enable,
   input  wire logic                        i_serial_en,
   input  wire logic [port_cfg_pkg::NFUNC-1:0] i_func_en,
   input  wire logic [31:0]                 i_bypass,
   output logic      [31:0]                 o_claim,
   output logic      [port_cfg_pkg::NFUNC*5-1:0] o_func_pin,
   output logic      [port_cfg_pkg::NFUNC-1:0] o_func_hit
);
   logic [31:0] taken;
   logic        found;

   always_comb begin
      taken      = i_bypass;
      o_claim    = '0;
      o_func_pin = '0;
      o_func_hit = '0;
      found      = 1'b0;
      // Serial pair is fixed, regardless of bypass
      if (i_enable && i_serial_en) begin
         o_claim = port_cfg_pkg::SERIAL_PIN_MASK;
         taken   = taken | port_cfg_pkg::SERIAL_PIN_MASK;
      end
      for (int k = 0; k < port_cfg_pkg::NFUNC; k++) begin
         found = 1'b0;
         if (i_enable && i_func_en[k]) begin
            for (int n = 0; n < port_cfg_pkg::NPIN; n++) begin
               if (!found && !taken[n]) begin
                  found               = 1'b1;
                  taken[n]            = 1'b1;
                  o_claim[n]          = 1'b1;
                  o_func_pin[k*5 +: 5] = 5'(n);
                  o_func_hit[k]       = 1'b1;
               end
            end
         end
      end
   end
endmodule
`default_nettype wire

// *** src/port_pin_mode_config.sv ***
// Port pin mode control with APB register access, pin matrix and event capture.
// Assumes pad inputs synchronous to i_mclk and an external pad model resolving oe/out/pull.
//
// Behaviour
// - Reset: pads high-Z, pull-ups on until enable
// - Analog pin: driver, receiver off; pull-up off once the matrix is enabled
// - Analog pin reads back as zero
// - Push-pull drives pad high or low
// - Open-drain drives only low, else high-Z
// - Undriven digital pad gets weak pull-up
// - Pull-up off while driving low
// - Global disable turns all pull-ups off once the matrix is enabled
// - Digital read returns pad level, not latch
// - Bypassed pin never claimed by matrix, except serial pins 4 and 5
// - Serial port fixed on pins 4 and 5
// - Enabled transition raises event request
// - Events work whatever the bypass setting
// - No event capture on analog pins
`timescale 1ns/10ps
`default_nettype none
module port_pin_mode_config (
   input  wire logic                        i_mclk,
   input  wire logic                        i_rst_n,
   input  wire logic                        i_psel,
   input  wire logic                        i_penable,
   input  wire logic                        i_pwrite,
   input  wire logic [7:0]                  i_paddr,
   input  wire logic [31:0]                 i_pwdata,
   output logic      [31:0]                 o_prdata,
   output logic                             o_pready,
   output logic                             o_pslverr,
   input  wire logic [31:0]                 i_pad_in,
   output logic      [31:0]                 o_pad_out,
   output logic      [31:0]                 o_pad_oe,
   output logic      [31:0]                 o_pullup_en,
   output logic      [31:0]                 o_rx_en,
   input  wire logic                        i_serial_tx,
   output logic                             o_serial_rx,
   input  wire logic [port_cfg_pkg::NFUNC-1:0] i_func_out,
   output logic      [port_cfg_pkg::NFUNC-1:0] o_func_in,
   output logic                             o_ext_irq0,
   output logic                             o_ext_irq1,
   output logic                             o_port_match
);
   localparam int NF = port_cfg_pkg::NFUNC;

   // Software registers, bit n of each 32-bit one steers pin n
   logic [31:0] analog_digital_r;   // pin_analog_digital_select
   logic [31:0] drive_sel_r;        // pin_output_drive_select
   logic [31:0] bypass_r;           // matrix_bypass_bits
   logic [31:0] out_latch_r;
   logic [31:0] match_mask_r;
   logic [31:0] match_value_r;
   logic [1:0]  ctrl_r;
   logic [3:0]  matrix_sel_r;
   logic [7:0]  irq_cfg_r;
   logic [31:0] pad_prev_r;

   logic        pin_matrix_enable;
   logic        pullup_global_disable;
   logic        setup_phase;
   logic        wr_access;
   logic [31:0] pin_read;
   logic [31:0] rd_mux;
   logic        addr_hit;
   logic [31:0] claim;
   logic [NF*5-1:0] func_pin;
   logic [NF-1:0]   func_hit;
   logic [31:0] pin_val;
   logic [31:0] oe_nxt;
   logic [31:0] out_nxt;
   logic [31:0] pull_nxt;
   logic [31:0] rx_nxt;
   logic [NF-1:0] func_in_nxt;
   logic [4:0]  irq0_pin;
   logic [4:0]  irq1_pin;
   logic        irq0_nxt;
   logic        irq1_nxt;
   logic        match_nxt;

   assign pin_matrix_enable     = ctrl_r[port_cfg_pkg::CTRL_MATRIX_EN_BIT];
   assign pullup_global_disable = ctrl_r[port_cfg_pkg::CTRL_PULLUP_DIS_BIT];
   assign setup_phase = i_psel && !i_penable;
   assign wr_access   = i_psel && i_penable && o_pready && i_pwrite;

   // Analog pins read zero, digital pins read the pad itself
   assign pin_read = i_pad_in & analog_digital_r;

   function automatic logic is_mapped(input logic [7:0] a);
      is_mapped = (a == port_cfg_pkg::OFS_CTRL) || (a == port_cfg_pkg::OFS_ANALOG_DIG) ||
                  (a == port_cfg_pkg::OFS_DRIVE_SEL) || (a == port_cfg_pkg::OFS_BYPASS) ||
                  (a == port_cfg_pkg::OFS_OUT_LATCH) || (a == port_cfg_pkg::OFS_PIN_READ) ||
                  (a == port_cfg_pkg::OFS_MATCH_MASK) || (a == port_cfg_pkg::OFS_MATCH_VALUE) ||
                  (a == port_cfg_pkg::OFS_MATRIX_SEL) || (a == port_cfg_pkg::OFS_EXT_IRQ_CFG);
   endfunction

   function automatic logic wr_hit(input logic we, input logic [7:0] a, input logic [7:0] ofs);
      wr_hit = we && (a == ofs);
   endfunction

   assign addr_hit = is_mapped(i_paddr);

   always_comb begin
      rd_mux = '0;
      unique case (i_paddr)
         port_cfg_pkg::OFS_CTRL:        rd_mux = {30'h0, ctrl_r};
         port_cfg_pkg::OFS_ANALOG_DIG:  rd_mux = analog_digital_r;
         port_cfg_pkg::OFS_DRIVE_SEL:   rd_mux = drive_sel_r;
         port_cfg_pkg::OFS_BYPASS:      rd_mux = bypass_r;
         port_cfg_pkg::OFS_OUT_LATCH:   rd_mux = out_latch_r;
         port_cfg_pkg::OFS_PIN_READ:    rd_mux = pin_read;
         port_cfg_pkg::OFS_MATCH_MASK:  rd_mux = match_mask_r;
         port_cfg_pkg::OFS_MATCH_VALUE: rd_mux = match_value_r;
         port_cfg_pkg::OFS_MATRIX_SEL:  rd_mux = {28'h0, matrix_sel_r};
         port_cfg_pkg::OFS_EXT_IRQ_CFG: rd_mux = {24'h0, irq_cfg_r};
         default:                       rd_mux = '0;
      endcase
   end

   // Zero-wait slave: ready in the first access cycle, data sampled at setup
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_pready  <= 1'b0;
         o_pslverr <= 1'b0;
         o_prdata  <= '0;
      end else begin
         o_pready  <= setup_phase;
         o_pslverr <= setup_phase && !addr_hit;
         o_prdata  <= (setup_phase && !i_pwrite) ? rd_mux : '0;
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ctrl_r           <= port_cfg_pkg::RST_CTRL;
         analog_digital_r <= port_cfg_pkg::RST_ANALOG_DIG;
         drive_sel_r      <= port_cfg_pkg::RST_DRIVE_SEL;
         bypass_r         <= port_cfg_pkg::RST_BYPASS;
         out_latch_r      <= port_cfg_pkg::RST_OUT_LATCH;
         match_mask_r     <= port_cfg_pkg::RST_MATCH_MASK;
         match_value_r    <= port_cfg_pkg::RST_MATCH_VALUE;
         matrix_sel_r     <= port_cfg_pkg::RST_MATRIX_SEL;
         irq_cfg_r        <= port_cfg_pkg::RST_EXT_IRQ_CFG;
      end else begin
         if (wr_hit(wr_access, i_paddr, port_cfg_pkg::OFS_CTRL))
            ctrl_r <= i_pwdata[1:0];
         if (wr_hit(wr_access, i_paddr, port_cfg_pkg::OFS_ANALOG_DIG))
            analog_digital_r <= i_pwdata;
         if (wr_hit(wr_access, i_paddr, port_cfg_pkg::OFS_DRIVE_SEL))
            drive_sel_r <= i_pwdata;
         if (wr_hit(wr_access, i_paddr, port_cfg_pkg::OFS_BYPASS))
            bypass_r <= i_pwdata;
         if (wr_hit(wr_access, i_paddr, port_cfg_pkg::OFS_OUT_LATCH))
            out_latch_r <= i_pwdata;
         if (wr_hit(wr_access, i_paddr, port_cfg_pkg::OFS_MATCH_MASK))
            match_mask_r <= i_pwdata;
         if (wr_hit(wr_access, i_paddr, port_cfg_pkg::OFS_MATCH_VALUE))
            match_value_r <= i_pwdata;
         if (wr_hit(wr_access, i_paddr, port_cfg_pkg::OFS_MATRIX_SEL))
            matrix_sel_r <= i_pwdata[3:0];
         if (wr_hit(wr_access, i_paddr, port_cfg_pkg::OFS_EXT_IRQ_CFG))
            irq_cfg_r <= i_pwdata[7:0];
      end
   end

   pin_matrix_assign u_matrix (
      .i_enable    (pin_matrix_enable),
      .i_serial_en (matrix_sel_r[port_cfg_pkg::MSEL_SERIAL_BIT]),
      .i_func_en   (matrix_sel_r[port_cfg_pkg::MSEL_FUNC_LSB +: NF]),
      .i_bypass    (bypass_r),
      .o_claim     (claim),
      .o_func_pin  (func_pin),
      .o_func_hit  (func_hit)
   );

   // Output value per pin: serial, matrix function, or latch
   generate
      for (genvar n = 0; n < port_cfg_pkg::NPIN; n++) begin : g_pin
         logic [NF-1:0] own;
         for (genvar k = 0; k < NF; k++) begin : g_f
            assign own[k] = func_hit[k] && (func_pin[k*5 +: 5] == 5'(n));
         end
         if (n == port_cfg_pkg::SERIAL_TX_PIN) begin : g_tx
            assign pin_val[n] = claim[n] ? i_serial_tx : out_latch_r[n];
         end else if (n == port_cfg_pkg::SERIAL_RX_PIN) begin : g_rx
            assign pin_val[n] = claim[n] ? 1'b1 : out_latch_r[n];
         end else begin : g_gen
            assign pin_val[n] = (|own) ? |(own & i_func_out) : out_latch_r[n];
         end
      end
      for (genvar k = 0; k < NF; k++) begin : g_fin
         assign func_in_nxt[k] = func_hit[k] && pin_read[func_pin[k*5 +: 5]];
      end
   endgenerate

   // Once enabled, push-pull digital pins always drive; open-drain drives only a low
   assign oe_nxt  = pin_matrix_enable ? (analog_digital_r & (drive_sel_r | ~pin_val))
                                      : '0;
   assign out_nxt = pin_matrix_enable ? (analog_digital_r & drive_sel_r & pin_val) : '0;
   // Once enabled, pull-up only on undriven or high digital pads, not on driven-low ones
   assign pull_nxt = pin_matrix_enable
                   ? (analog_digital_r & ~{32{pullup_global_disable}} & ~(oe_nxt & ~pin_val))
                   : '1;
   assign rx_nxt = analog_digital_r;

   // Event capture ignores bypass; gated by digital mode so a pin turned analog fakes no edge
   assign irq0_pin = port_cfg_pkg::IRQ_PORT_BASE +
                     5'(irq_cfg_r[port_cfg_pkg::IRQ0_SEL_LSB +: port_cfg_pkg::IRQ_SEL_W]);
   assign irq1_pin = port_cfg_pkg::IRQ_PORT_BASE +
                     5'(irq_cfg_r[port_cfg_pkg::IRQ1_SEL_LSB +: port_cfg_pkg::IRQ_SEL_W]);
   assign irq0_nxt = analog_digital_r[irq0_pin] &&
                     (pin_read[irq0_pin] != pad_prev_r[irq0_pin]) &&
                     (pin_read[irq0_pin] == irq_cfg_r[port_cfg_pkg::IRQ0_POL_BIT]);
   assign irq1_nxt = analog_digital_r[irq1_pin] &&
                     (pin_read[irq1_pin] != pad_prev_r[irq1_pin]) &&
                     (pin_read[irq1_pin] == irq_cfg_r[port_cfg_pkg::IRQ1_POL_BIT]);
   assign match_nxt = |((pin_read ^ match_value_r) & match_mask_r & analog_digital_r);

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_pad_oe     <= '0;
         o_pad_out    <= '0;
         o_pullup_en  <= '1;
         o_rx_en      <= '1;
         o_func_in    <= '0;
         o_serial_rx  <= 1'b1;
         pad_prev_r   <= '0;
         o_ext_irq0   <= 1'b0;
         o_ext_irq1   <= 1'b0;
         o_port_match <= 1'b0;
      end else begin
         o_pad_oe     <= oe_nxt;
         o_pad_out    <= out_nxt;
         o_pullup_en  <= pull_nxt;
         o_rx_en      <= rx_nxt;
         o_func_in    <= func_in_nxt;
         o_serial_rx  <= claim[port_cfg_pkg::SERIAL_RX_PIN] ?
                         pin_read[port_cfg_pkg::SERIAL_RX_PIN] : 1'b1;
         pad_prev_r   <= pin_read;
         o_ext_irq0   <= irq0_nxt;
         o_ext_irq1   <= irq1_nxt;
         o_port_match <= match_nxt;
      end
   end

   AST_RESET_HIZ: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      !pin_matrix_enable |=> (o_pad_oe == '0) && (&o_pullup_en))
      else $error("pad driven or pull-up off before matrix enable");

   AST_ANALOG_OFF: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      pin_matrix_enable |=> (((o_pad_oe | o_pullup_en | o_rx_en) & ~$past(analog_digital_r)) == '0))
      else $error("analog pin has driver, pull-up or receiver on");

   AST_PIN_READBACK: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (setup_phase && !i_pwrite && i_paddr == port_cfg_pkg::OFS_PIN_READ)
      |=> o_prdata == ($past(i_pad_in) & $past(analog_digital_r)))
      else $error("pin read not pad level masked by digital mode");

   AST_PUSH_PULL: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      pin_matrix_enable |=> ((~o_pad_oe & $past(analog_digital_r & drive_sel_r)) == '0))
      else $error("push-pull digital pin not driven");

   AST_OPEN_DRAIN_HIGH: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      pin_matrix_enable |=> ((o_pad_out & ~$past(drive_sel_r)) == '0))
      else $error("open-drain pin driving high");

   AST_PULL_UNDRIVEN: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (pin_matrix_enable && !pullup_global_disable)
      |=> ((~o_pad_oe & $past(analog_digital_r) & ~o_pullup_en) == '0))
      else $error("undriven digital pin lacks pull-up");

   AST_PULL_LOW_OFF: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      ##1 ((o_pad_oe & ~o_pad_out & o_pullup_en) == '0))
      else $error("pull-up on while driving low");

   AST_GLOBAL_PULL_OFF: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (pin_matrix_enable && pullup_global_disable) |=> (o_pullup_en == '0))
      else $error("pull-up on under global disable");

   AST_BYPASS_RESPECTED: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (claim & bypass_r & ~port_cfg_pkg::SERIAL_PIN_MASK) == '0)
      else $error("matrix claimed a bypassed pin");

   AST_SERIAL_FIXED: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (pin_matrix_enable && matrix_sel_r[port_cfg_pkg::MSEL_SERIAL_BIT])
      |-> (claim & port_cfg_pkg::SERIAL_PIN_MASK) == port_cfg_pkg::SERIAL_PIN_MASK)
      else $error("serial pair not on pins 4 and 5");

   AST_EVENT_EDGE: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (irq_cfg_r[port_cfg_pkg::IRQ0_POL_BIT] && analog_digital_r[irq0_pin]
       && !pad_prev_r[irq0_pin] && i_pad_in[irq0_pin]) |=> o_ext_irq0)
      else $error("enabled rising edge raised no event");

   AST_ANALOG_NO_EVENT: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      !analog_digital_r[irq0_pin] |=> !o_ext_irq0)
      else $error("event raised on analog pin");
endmodule
`default_nettype wire

// *** testbench/pad_model.sv ***
// Pad model for the pins: resolves cell driver, external driver and weak pull-up.
// Assumes the bench only drives externally a pin that the cell leaves undriven.
`timescale 1ns/10ps
`default_nettype none
module pad_model (
   input  wire logic        i_mclk,
   input  wire logic [31:0] i_oe,
   input  wire logic [31:0] i_out,
   input  wire logic [31:0] i_pull,
   input  wire logic [31:0] i_ext_en,
   input  wire logic [31:0] i_ext_val,
   output logic      [31:0] o_pad
);
   logic [31:0] float_r = 32'h5555_5555;

   // Floating pads toggle so no stale level can pass for a real one
   always @(posedge i_mclk) begin
      float_r <= ~float_r;
   end

   assign o_pad = (i_oe & i_out)
                | (~i_oe & i_ext_en & i_ext_val)
                | (~i_oe & ~i_ext_en & (i_pull | float_r));
endmodule
`default_nettype wire

// *** testbench/port_pin_mode_config_bench.sv ***
// Self-checking bench for the port pin mode block over APB.
// Assumes the pad model closes the loop from pad outputs to i_pad_in.
`timescale 1ns/10ps
`default_nettype none
module port_pin_mode_config_bench;
   logic        mclk = 1'b0;
   logic        rst_n = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [31:0] pad_in;
   logic [31:0] pad_out;
   logic [31:0] pad_oe;
   logic [31:0] pullup_en;
   logic [31:0] rx_en;
   logic        serial_tx = 1'b1;
   logic        serial_rx;
   logic [2:0]  func_out = 3'b110;
   logic [2:0]  func_in;
   logic        irq0;
   logic        irq1;
   logic        port_match;
   logic [31:0] ext_en = 32'h0000_0901;
   logic [31:0] ext_val = 32'h0000_0901;
   int          failures = 0;
   int          total_checks = 0;
   int          cycles = 0;
   int          irq0_cnt = 0;
   int          irq1_cnt = 0;

   always #5 mclk = ~mclk;

   port_pin_mode_config i_port_pin_mode_config (
      .i_mclk(mclk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
      .o_pready(pready), .o_pslverr(pslverr), .i_pad_in(pad_in), .o_pad_out(pad_out),
      .o_pad_oe(pad_oe), .o_pullup_en(pullup_en), .o_rx_en(rx_en),
      .i_serial_tx(serial_tx), .o_serial_rx(serial_rx), .i_func_out(func_out),
      .o_func_in(func_in), .o_ext_irq0(irq0), .o_ext_irq1(irq1),
      .o_port_match(port_match));

   pad_model i_pad_model (
      .i_mclk(mclk), .i_oe(pad_oe), .i_out(pad_out), .i_pull(pullup_en),
      .i_ext_en(ext_en), .i_ext_val(ext_val), .o_pad(pad_in));

   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (irq0 === 1'b1) irq0_cnt <= irq0_cnt + 1;
      if (irq1 === 1'b1) irq1_cnt <= irq1_cnt + 1;
      if (cycles == 5000) begin
         failures = failures + 1;
         test_done();
      end
   end

   task test_done;
      if (failures == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
            output logic [31:0] rd, output logic err);
      @(posedge mclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      // Answer taken at the very edge where ready is sampled high
      while (pready !== 1'b1) begin
         @(posedge mclk);
      end
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
      repeat (2) @(negedge mclk);
   endtask

   task rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0, r, e);
      chk(r, exp);
      chk({31'h0, e}, {31'h0, exp_err});
   endtask

   task ext(input logic [4:0] n, input logic v);
      @(posedge mclk);
      ext_val[n] <= v;
      repeat (4) @(negedge mclk);
   endtask

   initial begin
      repeat (10) @(posedge mclk);
      rst_n <= 1'b1;
      @(negedge mclk);
      chk(pad_oe, 32'h0);
      chk(pullup_en, 32'hffff_ffff);
      rd_chk(port_cfg_pkg::OFS_ANALOG_DIG, port_cfg_pkg::RST_ANALOG_DIG, 1'b0);
      rd_chk(port_cfg_pkg::OFS_DRIVE_SEL, port_cfg_pkg::RST_DRIVE_SEL, 1'b0);
      rd_chk(port_cfg_pkg::OFS_BYPASS, port_cfg_pkg::RST_BYPASS, 1'b0);
      rd_chk(port_cfg_pkg::OFS_OUT_LATCH, port_cfg_pkg::RST_OUT_LATCH, 1'b0);
      rd_chk(port_cfg_pkg::OFS_CTRL, {30'h0, port_cfg_pkg::RST_CTRL}, 1'b0);
      rd_chk(8'h40, 32'h0, 1'b1);
      wr(port_cfg_pkg::OFS_ANALOG_DIG, 32'hffff_fffe);
      wr(port_cfg_pkg::OFS_DRIVE_SEL, 32'h0000_0612);
      wr(port_cfg_pkg::OFS_BYPASS, 32'hffff_f1ff);
      wr(port_cfg_pkg::OFS_OUT_LATCH, 32'hffff_fff9);
      wr(port_cfg_pkg::OFS_MATRIX_SEL, 32'h0000_0007);
      wr(port_cfg_pkg::OFS_EXT_IRQ_CFG, 32'h0000_00b8);
      wr(port_cfg_pkg::OFS_MATCH_MASK, 32'h0000_0800);
      chk(pad_oe, 32'h0);
      chk(pullup_en, 32'hffff_ffff);
      wr(port_cfg_pkg::OFS_CTRL, 32'h1);
      chk(pad_oe, 32'h0000_0616);
      chk(pad_out, 32'h0000_0410);
      chk(pullup_en, 32'hffff_fdf8);
      chk(rx_en, 32'hffff_fffe);
      rd_chk(port_cfg_pkg::OFS_PIN_READ, 32'hffff_fdf8, 1'b0);
      chk({29'h0, func_in}, 32'h2);
      chk({31'h0, port_match}, 32'h1);
      wr(port_cfg_pkg::OFS_CTRL, 32'h3);
      chk(pullup_en, 32'h0);
      chk(pad_oe, 32'h0000_0616);
      wr(port_cfg_pkg::OFS_CTRL, 32'h1);
      // Third function gets the last free pin, released high in open drain
      wr(port_cfg_pkg::OFS_MATRIX_SEL, 32'h0000_000f);
      chk(pad_oe, 32'h0000_0616);
      chk({29'h0, func_in}, 32'h6);
      @(posedge mclk);
      serial_tx <= 1'b0;
      ext_en[5] <= 1'b1;
      ext_val[5] <= 1'b0;
      repeat (3) @(negedge mclk);
      chk(pad_out, 32'h0000_0400);
      chk({31'h0, serial_rx}, 32'h0);
      ext(5'd8, 1'b0);
      ext(5'd8, 1'b1);
      chk(irq0_cnt, 32'h1);
      ext(5'd11, 1'b0);
      chk({31'h0, port_match}, 32'h0);
      ext(5'd11, 1'b1);
      chk(irq1_cnt, 32'h1);
      wr(port_cfg_pkg::OFS_ANALOG_DIG, 32'hffff_fefe);
      ext(5'd8, 1'b0);
      ext(5'd8, 1'b1);
      chk(irq0_cnt, 32'h1);
      test_done();
   end
endmodule
`default_nettype wire
